// File: verilog/drive_cmd_defs.vh
// Constants for the fieldbus drive command interpreter.
`ifndef DRIVE_CMD_DEFS_VH
`define DRIVE_CMD_DEFS_VH

// Clock rate and supervision timing.
`define CLK_FREQ_HZ     40000000
`define TICK_MS         1
`define MS_CYCLES_CALC  ((`CLK_FREQ_HZ / 1000) * `TICK_MS)
`define WD_PERIOD_MS    1000
`define WD_HALF_MS      (`WD_PERIOD_MS / 2)

// Command word bit positions.
`define CW_ON           0
`define CW_NO_COAST     1
`define CW_NO_QUICK     2
`define CW_START        3
`define CW_RAMP_FORCE   4
`define CW_RAMP_HOLD    5
`define CW_REF_ENABLE   6
`define CW_FAULT_ACK    7
`define CW_INCH1        8
`define CW_INCH2        9
`define CW_BUS_EN       10
`define CW_ALIVE        11

// State report word bit positions.
`define SW_READY1       0
`define SW_READY2       1
`define SW_ENABLE       2
`define SW_FAULT        3
`define SW_NO_COAST     4
`define SW_NO_QUICK     5
`define SW_INHIBIT      6
`define SW_WARNING      7
`define SW_AT_REF       8
`define SW_BUS_CTRL     9
`define SW_RUNNING      12
`define SW_READY        13
`define SW_ALIVE_ECHO   15

// Control place code that selects the fieldbus.
`define CP_FIELDBUS     2'h3

// Drive states.
`define ST_NOT_READY    3'h0
`define ST_INHIBIT      3'h1
`define ST_READY_SW_ON  3'h2
`define ST_READY_OP     3'h3
`define ST_RUNNING      3'h4
`define ST_FAULT        3'h5

// Stop behaviours reported on the stop kind output.
`define STOP_NONE       2'h0
`define STOP_RAMP       2'h1
`define STOP_COAST      2'h2

// Jogging source.
`define JOG_NONE        2'h0
`define JOG_BUS         2'h1
`define JOG_IO          2'h2

// Reset values.
`define RST_WORD        16'h0000

`endif

// File: verilog/pin_filter.v
// Three-stage synchroniser and agreement filter for the I/O pins.
`timescale 1ns/1ps
`default_nettype none

module pin_filter
(
  input  wire       CLK_IN,      // Drive clock.
  input  wire       RST_N_IN,    // Synchronous reset, active low.
  input  wire [3:0] pins_in,     // Raw asynchronous pins.
  output reg  [3:0] clean_out    // Filtered pin levels.
);

  reg [3:0] sync1;  // First stage, read by the second only.
  reg [3:0] sync2;  // Second stage.
  reg [3:0] sync3;  // Third stage.

  ////////////////////////////////////////////////////////////////////////////
  // A level only counts once stages two and three agree, which also
  // rejects a single-cycle glitch that slips past the first stage.
  always @(posedge CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      sync1     <= 4'h0;
      sync2     <= 4'h0;
      sync3     <= 4'h0;
      clean_out <= 4'h0;
    end
    else
    begin
      sync1     <= pins_in;
      sync2     <= sync1;
      sync3     <= sync2;
      clean_out <= (sync2 & ~(sync2 ^ sync3)) | (clean_out & (sync2 ^ sync3));
    end
  end

endmodule // pin_filter

`default_nettype wire

// File: verilog/alive_watchdog.v
// Supervision of the master's alive toggle bit.
`timescale 1ns/1ps
`default_nettype none
`include "drive_cmd_defs.vh"

module alive_watchdog
#(
  parameter MS_CYCLES = `MS_CYCLES_CALC  // Clock cycles per millisecond.
)
(
  input  wire        CLK_IN,       // Drive clock.
  input  wire        RST_N_IN,     // Synchronous reset, active low.
  input  wire        enable_in,    // Supervision active.
  input  wire        toggle_in,    // Alive bit as last received.
  input  wire [15:0] delay_ms_in,  // Extra tolerance in ms.
  input  wire        ack_in,       // Fault acknowledge pulse.
  output reg         fault_out     // Sticky communication fault.
);

  localparam [31:0] MS_WIDE   = MS_CYCLES - 1;   // Divider end, full width.
  localparam [31:0] HALF_WIDE = `WD_HALF_MS;      // Half period, full width.
  localparam [15:0] MS_LAST   = MS_WIDE[15:0];   // Last divider count.
  localparam [16:0] HALF_MS   = HALF_WIDE[16:0]; // Nominal half period.

  reg  [15:0] div;        // Millisecond divider.
  reg  [16:0] ms_count;   // Milliseconds since the last toggle.
  reg         last_tog;   // Previous alive bit.
  wire        tick;       // One-cycle pulse per millisecond.
  wire        changed;    // Alive bit moved.
  wire [16:0] limit;      // Time allowed between toggles.
  wire        timeout;    // Toggle overdue.

  assign tick    = (div == MS_LAST);
  assign changed = (toggle_in != last_tog);
  assign limit   = HALF_MS + {1'b0, delay_ms_in};
  assign timeout = enable_in && (ms_count >= limit);

  ////////////////////////////////////////////////////////////////////////////
  // Divider and age counter. The counter saturates so a long silence
  // cannot wrap round and hide the fault.
  always @(posedge CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      div      <= 16'h0000;
      ms_count <= 17'h00000;
      last_tog <= 1'b0;
    end
    else
    begin
      last_tog <= toggle_in;
      div      <= tick ? 16'h0000 : div + 16'h0001;
      if (!enable_in || changed)
        ms_count <= 17'h00000;
      else if (tick && (ms_count != 17'h1ffff))
        ms_count <= ms_count + 17'h00001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky fault; a timeout in the acknowledge cycle wins.
  always @(posedge CLK_IN)
  begin
    if (!RST_N_IN)
      fault_out <= 1'b0;
    else if (timeout)
      fault_out <= 1'b1;  // [RULE15] [RULE22]
    else if (ack_in)
      fault_out <= 1'b0;
  end

endmodule // alive_watchdog

`default_nettype wire

// File: verilog/fieldbus_drive_control.v
// Fieldbus command word interpreter and drive state machine.
// Behaviour
// RULE1: Fault, warning, running, ready bits from drive.
// RULE2: At-reference bit when actual equals reference.
// RULE3: Readiness, stop, inhibit, bus bits from machine.
// RULE4: On rising edge leaves inhibit, ready to run.
// RULE5: On low gives ramp stop, ready to switch.
// RULE6: Coast bit low coasts into inhibit.
// RULE7: Quick bit low uses configured quick stop.
// RULE8: Start bit runs; low stops by configuration.
// RULE9: Ramp force low zeroes ramp, top priority.
// RULE10: Hold low freezes ramp, beats reference bit.
// RULE11: Reference bit low zeroes reference, lowest.
// RULE12: Acknowledge edge clears faults, maybe inhibit.
// RULE13: Inching bits run at own fixed speeds.
// RULE14: Bus enable works only with fieldbus place.
// RULE15: Missing alive toggles raise communication fault.
// RULE16: Bus jog is start with ramp bits zero.
// RULE17: Ramp bits honoured again after zero speed.
// RULE18: I/O jog starts drive when jog enabled.
// RULE19: Inching ignored while start is active.
// RULE20: Both inching requests together stop drive.
// RULE21: Alive bit echoed in report bit fifteen.
// RULE22: Zero watchdog delay disables supervision.
// RULE23: Bus enable removed while running coasts.
// RULE24: Encoded machine with six drive states.
`timescale 1ns/1ps
`default_nettype none
`include "drive_cmd_defs.vh"

module fieldbus_drive_control
#(
  parameter MS_CYCLES = `MS_CYCLES_CALC  // Cycles per millisecond.
)
(
  input  wire        CLK_IN,            // Drive clock, 40 MHz.
  input  wire        RST_N_IN,          // Synchronous reset, active low.
  input  wire [15:0] CMD_WORD_IN,       // Command word from the bus.
  input  wire        CMD_VALID_IN,      // New command word strobe.
  input  wire [1:0]  CTRL_PLACE_IN,     // Control place select.
  input  wire [1:0]  QSTOP_MODE_IN,     // Quick stop behaviour.
  input  wire [1:0]  STOP_MODE_IN,      // Normal stop behaviour.
  input  wire [15:0] WD_DELAY_IN,       // Watchdog delay in ms.
  input  wire        FAULT_IN,          // Drive fault active.
  input  wire        WARNING_IN,        // Drive warning active.
  input  wire        VOLT_OFF_IN,       // Fault removed output voltage.
  input  wire [15:0] SPEED_ACT_IN,      // Actual speed.
  input  wire [15:0] SPEED_REF_IN,      // Speed reference.
  input  wire        IO_START_IN,       // I/O start pin.
  input  wire        IO_JOG1_IN,        // I/O jog 1 pin.
  input  wire        IO_JOG2_IN,        // I/O jog 2 pin.
  input  wire        IO_JOG_EN_IN,      // Jogging enable pin.
  output reg  [15:0] STATUS_WORD_OUT,   // State report word.
  output reg         RUN_OUT,           // Modulation command.
  output reg  [1:0]  STOP_KIND_OUT,     // Stop in progress.
  output reg         RAMP_ZERO_OUT,     // Ramp output forced to zero.
  output reg         RAMP_HOLD_OUT,     // Ramp frozen.
  output reg         REF_ZERO_OUT,      // Reference forced to zero.
  output reg  [1:0]  JOG_SEL_OUT,       // Inching speed select.
  output reg         FAULT_ACK_OUT,     // Fault acknowledge pulse.
  output reg         BUS_FAULT_OUT      // Communication fault.
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.
  reg  [15:0] cmd_word;     // Last accepted command word.
  reg         on_rise;      // Rising edge of the on bit.
  reg         ack_rise;     // Rising edge of the acknowledge bit.
  reg  [2:0]  state;        // Drive state.
  reg  [2:0]  next_state;   // Next drive state.
  reg  [1:0]  jog_mode;     // Source of the present jog run.
  reg  [1:0]  next_jog;     // Next jog source.
  reg  [1:0]  stop_ev;      // Stop started this cycle.
  reg         jog_recover;  // Ramp bits masked after a bus jog.
  reg         next_recover; // Next mask value.
  reg         bus_was;      // Bus control active last cycle.
  wire [3:0]  pins;         // Filtered I/O pins.
  wire        io_start;     // Filtered start pin.
  wire        io_j1;        // Filtered jog 1.
  wire        io_j2;        // Filtered jog 2.
  wire        io_jen;       // Filtered jog enable.
  wire        bus_place;    // Fieldbus is the control place.
  wire        bus_active;   // Bus control in force.
  wire        bus_lost;     // Bus control just withdrawn.
  wire        zero_speed;   // Drive stands still.
  wire        wd_fault;     // Alive supervision fault.
  wire        fault_any;    // Any fault present.
  wire        eff_on;       // On command as seen by the machine.
  wire        run_cmd;      // Start command from the active place.
  wire        ramp_bits_0;  // Ramp bits all low.
  wire        bus_jog_req;  // Valid bus jog request.
  wire        io_jog_req;   // Valid I/O jog request.
  wire        both_jog;     // Both inching requests at once.
  wire        coast_req;    // Coast stop from the bus.
  wire        quick_req;    // Quick stop from the bus.
  wire        honour;       // Ramp bits are obeyed.

  ////////////////////////////////////////////////////////////////////////////
  // Maps a configured stop behaviour onto a stop kind.
  function [1:0] stop_of;
    input [1:0] mode;
    begin
      stop_of = (mode == `STOP_COAST) ? `STOP_COAST : `STOP_RAMP;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pins come from outside the clock domain.
  pin_filter u_pins
  (
    .CLK_IN    (CLK_IN),
    .RST_N_IN  (RST_N_IN),
    .pins_in   ({IO_JOG_EN_IN, IO_JOG2_IN, IO_JOG1_IN, IO_START_IN}),
    .clean_out (pins)
  );

  assign io_start = pins[0];
  assign io_j1    = pins[1];
  assign io_j2    = pins[2];
  assign io_jen   = pins[3];

  ////////////////////////////////////////////////////////////////////////////
  // Command word capture and edge detection between successive words.
  // Edges are judged word to word, so a master that writes only on
  // change still gives exactly one edge.
  always @(posedge CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      cmd_word <= `RST_WORD;
      on_rise  <= 1'b0;
      ack_rise <= 1'b0;
    end
    else
    begin
      on_rise  <= CMD_VALID_IN & CMD_WORD_IN[`CW_ON] & ~cmd_word[`CW_ON];
      ack_rise <= CMD_VALID_IN & CMD_WORD_IN[`CW_FAULT_ACK] &
                  ~cmd_word[`CW_FAULT_ACK];
      if (CMD_VALID_IN)
        cmd_word <= CMD_WORD_IN;
    end
  end

  // Bus control needs the fieldbus control place as well. [RULE14]
  assign bus_place  = (CTRL_PLACE_IN == `CP_FIELDBUS);
  assign bus_active = bus_place & cmd_word[`CW_BUS_EN];
  assign bus_lost   = bus_was & ~bus_active;
  assign zero_speed = (SPEED_ACT_IN == 16'h0000);
  assign fault_any  = FAULT_IN | wd_fault;

  // Outside bus control the on, coast and quick bits are not followed.
  assign eff_on    = bus_active ? cmd_word[`CW_ON] : ~bus_place;
  assign coast_req = bus_active & ~cmd_word[`CW_NO_COAST];
  assign quick_req = bus_active & ~cmd_word[`CW_NO_QUICK];
  assign run_cmd   = bus_place ? (bus_active & cmd_word[`CW_START])
                               : io_start;

  // Jog requests.
  assign ramp_bits_0 = (cmd_word[6:4] == 3'h0);
  assign bus_jog_req = bus_active & cmd_word[`CW_START] & ramp_bits_0 &
                       (cmd_word[`CW_INCH1] ^ cmd_word[`CW_INCH2]); // [RULE16]
  assign io_jog_req  = io_jen & (io_j1 ^ io_j2) & ~run_cmd; // [RULE18] [RULE19]
  assign both_jog    = (bus_active & cmd_word[`CW_START] & ramp_bits_0 &
                        cmd_word[`CW_INCH1] & cmd_word[`CW_INCH2]) |
                       (io_jen & io_j1 & io_j2);

  ////////////////////////////////////////////////////////////////////////////
  // Alive toggle supervision, off when the delay is zero.
  alive_watchdog #(.MS_CYCLES(MS_CYCLES)) u_wd
  (
    .CLK_IN      (CLK_IN),
    .RST_N_IN    (RST_N_IN),
    .enable_in   (bus_active & (WD_DELAY_IN != 16'h0000)), // [RULE22]
    .toggle_in   (cmd_word[`CW_ALIVE]),
    .delay_ms_in (WD_DELAY_IN),
    .ack_in      (ack_rise),
    .fault_out   (wd_fault)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic. Stops that remove the drive from running are
  // checked last so they override the ordinary transitions. [RULE24]
  always @*
  begin
    next_state   = state;
    next_jog     = jog_mode;
    stop_ev      = `STOP_NONE;
    next_recover = jog_recover & ~zero_speed; // [RULE17]
    case (state)
      `ST_NOT_READY:
        next_state = `ST_INHIBIT;
      `ST_INHIBIT:
        begin
          if (on_rise & bus_active & ~coast_req & ~quick_req)
            next_state = `ST_READY_OP;    // [RULE4]
          else if (!bus_place)
            next_state = `ST_READY_SW_ON;
        end
      `ST_READY_SW_ON:
        begin
          if (eff_on)
            next_state = `ST_READY_OP;
        end
      `ST_READY_OP:
        begin
          if (!eff_on)
            next_state = `ST_READY_SW_ON; // [RULE5]
          else if (both_jog)
            next_state = `ST_READY_OP;    // [RULE20]
          else if (bus_jog_req)
          begin
            // A bus jog waits for standstill. [RULE16]
            if (zero_speed)
            begin
              next_state = `ST_RUNNING;
              next_jog   = `JOG_BUS;
            end
          end
          else if (io_jog_req)
          begin
            next_state = `ST_RUNNING;     // [RULE18]
            next_jog   = `JOG_IO;
          end
          else if (run_cmd)
            next_state = `ST_RUNNING;     // [RULE8]
        end
      `ST_RUNNING:
        begin
          if (!eff_on)
          begin
            next_state = `ST_READY_SW_ON; // [RULE5]
            next_jog   = `JOG_NONE;
            stop_ev    = `STOP_RAMP;
          end
          else if (both_jog && (jog_mode != `JOG_NONE))
          begin
            next_state = `ST_READY_OP;    // [RULE20]
            next_jog   = `JOG_NONE;
            stop_ev    = stop_of(STOP_MODE_IN);
          end
          else if ((jog_mode == `JOG_BUS) && !bus_jog_req)
          begin
            next_state   = `ST_READY_OP;
            next_jog     = `JOG_NONE;
            next_recover = 1'b1;          // [RULE17]
            stop_ev      = stop_of(STOP_MODE_IN);
          end
          else if ((jog_mode == `JOG_IO) && !io_jog_req)
          begin
            next_state = `ST_READY_OP;    // [RULE19]
            next_jog   = `JOG_NONE;
            stop_ev    = stop_of(STOP_MODE_IN);
          end
          else if ((jog_mode == `JOG_NONE) && !run_cmd)
          begin
            next_state = `ST_READY_OP;    // [RULE8]
            stop_ev    = stop_of(STOP_MODE_IN);
          end
        end
      `ST_FAULT:
        begin
          // Acknowledge only succeeds once the fault has gone. [RULE12]
          if (ack_rise && !fault_any)
            next_state = VOLT_OFF_IN ? `ST_INHIBIT : `ST_READY_SW_ON;
        end
      default:
        next_state = `ST_NOT_READY;
    endcase
    // Stops that override every ordinary transition.
    if ((state == `ST_READY_SW_ON) || (state == `ST_READY_OP) ||
        (state == `ST_RUNNING))
    begin
      if (bus_lost && (state == `ST_RUNNING))
      begin
        next_state = `ST_INHIBIT;         // [RULE23]
        stop_ev    = `STOP_COAST;
      end
      else if (coast_req)
      begin
        next_state = `ST_INHIBIT;         // [RULE6]
        stop_ev    = `STOP_COAST;
      end
      else if (quick_req)
      begin
        next_state = `ST_INHIBIT;         // [RULE7]
        stop_ev    = stop_of(QSTOP_MODE_IN);
      end
      if (next_state != `ST_RUNNING)
        next_jog = `JOG_NONE;
      if (state != `ST_RUNNING)
        stop_ev = `STOP_NONE;
    end
    if (fault_any && (state != `ST_FAULT) && (state != `ST_NOT_READY))
    begin
      next_state = `ST_FAULT;
      next_jog   = `JOG_NONE;
      stop_ev    = (state == `ST_RUNNING) ? `STOP_COAST : `STOP_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State registers. A new stop wins over the standstill clear.
  always @(posedge CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      state         <= `ST_NOT_READY;
      jog_mode      <= `JOG_NONE;
      jog_recover   <= 1'b0;
      bus_was       <= 1'b0;
      STOP_KIND_OUT <= `STOP_NONE;
    end
    else
    begin
      state       <= next_state;
      jog_mode    <= next_jog;
      jog_recover <= next_recover;
      bus_was     <= bus_active;
      if (stop_ev != `STOP_NONE)
        STOP_KIND_OUT <= stop_ev;
      else if (zero_speed || (next_state == `ST_RUNNING))
        STOP_KIND_OUT <= `STOP_NONE;
    end
  end

  // Ramp bits count only under bus control, outside jogging.
  assign honour = bus_active & ~jog_recover & (jog_mode == `JOG_NONE);

  ////////////////////////////////////////////////////////////////////////////
  // Drive command outputs. Force beats hold, hold beats reference.
  always @(posedge CLK_IN)
  begin
    if (!RST_N_IN)
    begin
      RUN_OUT       <= 1'b0;
      RAMP_ZERO_OUT <= 1'b0;
      RAMP_HOLD_OUT <= 1'b0;
      REF_ZERO_OUT  <= 1'b0;
      JOG_SEL_OUT   <= 2'h0;
      FAULT_ACK_OUT <= 1'b0;
      BUS_FAULT_OUT <= 1'b0;
    end
    else
    begin
      RUN_OUT       <= (state == `ST_RUNNING);
      RAMP_ZERO_OUT <= honour & ~cmd_word[`CW_RAMP_FORCE];  // [RULE9]
      RAMP_HOLD_OUT <= honour & cmd_word[`CW_RAMP_FORCE] &
                       ~cmd_word[`CW_RAMP_HOLD];            // [RULE10]
      REF_ZERO_OUT  <= honour & cmd_word[`CW_RAMP_FORCE] &
                       cmd_word[`CW_RAMP_HOLD] &
                       ~cmd_word[`CW_REF_ENABLE];           // [RULE11]
      // Judged on the next jog source, so a word with both inch bits
      // never reaches the select output while the stop is taken.
      if ((state == `ST_RUNNING) && (next_jog == `JOG_BUS))
        JOG_SEL_OUT <= cmd_word[9:8];                       // [RULE13]
      else if ((state == `ST_RUNNING) && (next_jog == `JOG_IO))
        JOG_SEL_OUT <= {io_j2, io_j1};                      // [RULE13]
      else
        JOG_SEL_OUT <= 2'h0;
      FAULT_ACK_OUT <= ack_rise;                            // [RULE12]
      BUS_FAULT_OUT <= wd_fault;                            // [RULE15]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State report word, rebuilt every cycle.
  always @(posedge CLK_IN)
  begin
    if (!RST_N_IN)
      STATUS_WORD_OUT <= `RST_WORD;
    else
    begin
      STATUS_WORD_OUT                 <= 16'h0000;
      STATUS_WORD_OUT[`SW_READY1]     <= (state == `ST_READY_SW_ON) ||
                                         (state == `ST_READY_OP) ||
                                         (state == `ST_RUNNING); // [RULE3]
      STATUS_WORD_OUT[`SW_READY2]     <= (state == `ST_READY_OP) ||
                                         (state == `ST_RUNNING); // [RULE3]
      STATUS_WORD_OUT[`SW_ENABLE]     <= (state == `ST_RUNNING); // [RULE3]
      STATUS_WORD_OUT[`SW_FAULT]      <= fault_any;              // [RULE1]
      STATUS_WORD_OUT[`SW_NO_COAST]   <= ~coast_req;             // [RULE3]
      STATUS_WORD_OUT[`SW_NO_QUICK]   <= ~quick_req;             // [RULE3]
      STATUS_WORD_OUT[`SW_INHIBIT]    <= (state == `ST_INHIBIT); // [RULE3]
      STATUS_WORD_OUT[`SW_WARNING]    <= WARNING_IN;             // [RULE1]
      STATUS_WORD_OUT[`SW_AT_REF]     <= (SPEED_ACT_IN ==
                                          SPEED_REF_IN);         // [RULE2]
      STATUS_WORD_OUT[`SW_BUS_CTRL]   <= bus_active;             // [RULE3]
      STATUS_WORD_OUT[`SW_RUNNING]    <= (state == `ST_RUNNING); // [RULE1]
      STATUS_WORD_OUT[`SW_READY]      <= ~fault_any &
                                         (state != `ST_NOT_READY); // [RULE1]
      STATUS_WORD_OUT[`SW_ALIVE_ECHO] <= cmd_word[`CW_ALIVE];    // [RULE21]
    end
  end

endmodule // fieldbus_drive_control

`default_nettype wire

// File: verilog/empty_placeholder_none.v
// Intentionally minimal unit; holds no logic.
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// File: sim/fbdc_checker_sva.sv
// Port-level assertions for the drive command interpreter.
`timescale 1ns/1ps
`default_nettype none
module fbdc_checker
(
  input wire logic        CLK_IN,          // Clock.
  input wire logic        RST_N_IN,        // Reset.
  input wire logic [15:0] CMD_WORD_IN,     // Command.
  input wire logic        CMD_VALID_IN,    // Strobe.
  input wire logic [15:0] WD_DELAY_IN,     // Delay.
  input wire logic        FAULT_IN,        // Fault.
  input wire logic [15:0] STATUS_WORD_OUT, // Report.
  input wire logic        RAMP_ZERO_OUT,   // Zero.
  input wire logic        RAMP_HOLD_OUT,   // Hold.
  input wire logic        REF_ZERO_OUT,    // Ref zero.
  input wire logic [1:0]  JOG_SEL_OUT,     // Jog.
  input wire logic        FAULT_ACK_OUT,   // Ack.
  input wire logic        BUS_FAULT_OUT    // Bus fault.
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  chk_fault_flag: assert property (
    FAULT_IN && $stable(FAULT_IN) |=> STATUS_WORD_OUT[3]) else $error("b3");
  chk_bus_fault: assert property (
    BUS_FAULT_OUT |-> STATUS_WORD_OUT[3]) else $error("wd to b3");
  chk_alive_echo: assert property (
    (CMD_VALID_IN && CMD_WORD_IN[11]) [*3] |=> STATUS_WORD_OUT[15])
    else $error("echo");
  chk_bus_off: assert property (
    (CMD_VALID_IN && !CMD_WORD_IN[10]) [*3] |=> !STATUS_WORD_OUT[9])
    else $error("b9");
  chk_ramp_prio: assert property (
    $onehot0({RAMP_ZERO_OUT, RAMP_HOLD_OUT, REF_ZERO_OUT})) else $error("ramp");
  chk_inch_both: assert property (
    JOG_SEL_OUT != 2'h3) else $error("inch");
  chk_ack_pulse: assert property (
    FAULT_ACK_OUT |=> !FAULT_ACK_OUT) else $error("ack");
  chk_wd_off: assert property (
    (!BUS_FAULT_OUT && WD_DELAY_IN == 16'h0) [*2] |=> !BUS_FAULT_OUT)
    else $error("wd off");
endmodule // fbdc_checker
bind fieldbus_drive_control fbdc_checker u_chk (.CLK_IN, .RST_N_IN,
  .CMD_WORD_IN, .CMD_VALID_IN, .WD_DELAY_IN, .FAULT_IN, .STATUS_WORD_OUT,
  .RAMP_ZERO_OUT, .RAMP_HOLD_OUT, .REF_ZERO_OUT, .JOG_SEL_OUT,
  .FAULT_ACK_OUT, .BUS_FAULT_OUT);
`default_nettype wire

// File: sim/plc_model.sv
// Master model: presents the command word and toggles the alive bit.
`timescale 1ns/1ps
`default_nettype none
module plc_model
#(
  parameter HALF = 2000 // Cycles per alive half period.
)
(
  input  wire logic        CLK_IN,   // Clock.
  input  wire logic        mute_in,  // Freeze alive bit.
  input  wire logic [15:0] word_in,  // Wanted word.
  output wire logic [15:0] cmd_out,  // Word to drive.
  output wire logic        valid_out // Held high.
);
  integer cnt = 0;    // Cycles since toggle.
  logic alive = 1'b0; // Alive level.
  // Off the sampling edge; a muted master starves the watchdog.
  always @(negedge CLK_IN)
  begin
    cnt = (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == 0 && !mute_in)
      alive = !alive;
  end
  assign cmd_out = {word_in[15:12], alive, word_in[10:0]};
  assign valid_out = 1'b1;
endmodule // plc_model
`default_nettype wire

// File: sim/fieldbus_drive_control_tb.sv
// Self-checking bench for the drive command interpreter.
`timescale 1ns/1ps
`default_nettype none
module fieldbus_drive_control_tb;
  logic clk = 1'b0, rst_n = 1'b0, mute = 1'b0;      // Clock, reset, mute.
  logic fault = 1'b0, warn = 1'b0, volt = 1'b0;     // Drive conditions.
  logic [1:0] mode = 2'h0, place = 2'h3;            // Stop mode, place.
  logic [3:0] io = 4'h0;                            // Jog and start pins.
  logic [15:0] word = 16'h0, wd_ms = 16'h0;         // Command, delay.
  logic [15:0] act = 16'h0, sref = 16'h5;           // Speeds.
  wire logic [15:0] cmd, status;
  wire logic valid, run, rz, rh, fz, ack, bf;
  wire logic [1:0] kind, jog;
  integer fail_count = 0, checks_done = 0, seed = 32'h342b62eb, i, n;
  plc_model #(.HALF(2000)) plc (.CLK_IN(clk), .mute_in(mute),
    .word_in(word), .cmd_out(cmd), .valid_out(valid));
  fieldbus_drive_control #(.MS_CYCLES(4)) dut (.CLK_IN(clk),
    .RST_N_IN(rst_n), .CMD_WORD_IN(cmd), .CMD_VALID_IN(valid),
    .CTRL_PLACE_IN(place), .QSTOP_MODE_IN(mode), .STOP_MODE_IN(mode),
    .WD_DELAY_IN(wd_ms), .FAULT_IN(fault), .WARNING_IN(warn),
    .VOLT_OFF_IN(volt), .SPEED_ACT_IN(act), .SPEED_REF_IN(sref),
    .IO_START_IN(io[0]), .IO_JOG1_IN(io[1]), .IO_JOG2_IN(io[2]),
    .IO_JOG_EN_IN(io[3]), .STATUS_WORD_OUT(status), .RUN_OUT(run),
    .STOP_KIND_OUT(kind), .RAMP_ZERO_OUT(rz), .RAMP_HOLD_OUT(rh),
    .REF_ZERO_OUT(fz), .JOG_SEL_OUT(jog), .FAULT_ACK_OUT(ack),
    .BUS_FAULT_OUT(bf));
  initial forever #12.5 clk = ~clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      $display("ERROR %0t: got %h want %h", $time, got, exp);
      fail_count++;
    end
  endtask
  // Words change at the falling edge, then settle for c cycles.
  task automatic go(input logic [15:0] w, input integer c);
    @(negedge clk) word = w;
    repeat (c) @(negedge clk);
  endtask
  task automatic arm;
    go(16'h0406, 1);
    go(16'h0407, 1);
    go(16'h047f, 5);
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    #(25 * 30000);
    $display("ERROR %0t: watchdog", $time);
    fail_count++;
    tally_and_finish;
  end
  initial
  begin
    repeat (4) @(negedge clk);
    chk(status, 16'h0000);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    chk(status, 16'h2070);
    for (i = 0; i < 4; i++)
    begin
      sref = 16'($random(seed));
      act = i[0] ? sref : 16'($random(seed));
      warn = i[1];
      repeat (3) @(negedge clk);
      chk(status[8:7], {act == sref, warn});
    end
    {act, sref, warn, wd_ms} = {16'h0, 16'h5, 1'b0, 16'ha};
    go(16'h0406, 1);
    go(16'h0407, 4);
    chk(status[9:0], 10'h233);
    go(16'h050f, 5);
    chk(jog, 2'h1);
    go(16'h070f, 4);
    chk(jog, 2'h0);
    act = 16'h100;
    arm;
    chk({run, status[12], status[2]}, 3'h7);
    for (i = 0; i < 8; i++)
    begin
      go(16'h040f | 16'(i << 4), 4);
      chk({rz, rh, fz}, {~i[0], i[0] & ~i[1], &i[1:0] & ~i[2]});
    end
    mode = $random(seed) & 1 ? 2'h2 : 2'h0;
    go(16'h0477, 4);
    chk(kind, mode == 2'h2 ? 2'h2 : 2'h1);
    arm;
    fault = 1'b1;
    repeat (4) @(negedge clk);
    chk({status[3], run}, 2'h2);
    {fault, volt} = 2'b01;
    go(16'h0486, 0);
    for (n = 0; n < 8 && ack !== 1'b1; n++) @(negedge clk);
    chk(ack, 1'b1);
    repeat (4) @(negedge clk);
    chk(status[6], 1'b1);
    arm;
    go(16'h047d, 4);
    chk({kind, status[6]}, 3'h5);
    go(16'h0406, 1);
    go(16'h0407, 4);
    io = 4'ha;
    repeat (8) @(negedge clk);
    chk({run, jog}, 3'h5);
    io = 4'h0;
    arm;
    place = 2'h0;
    repeat (4) @(negedge clk);
    chk({kind, status[9]}, 3'h4);
    place = 2'h3;
    arm;
    @(cmd[11]) mute = 1'b1;
    for (n = 0; n < 2200 && bf !== 1'b1; n++) @(negedge clk);
    chk(n >= 2020 && n <= 2060 && bf === 1'b1, 1'b1);
    tally_and_finish;
  end
endmodule // fieldbus_drive_control_tb
`default_nettype wire
